//--- iwb_pkg.sv
// Channel word buffer package: widths, field positions, states and
// the packed descriptor register layout.
// Assumes descriptor bit n of a 48-bit word sits at word index n.
package iwb_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int WORD_W      = 48;
    localparam int CHAR_W      = 6;
    localparam int POS_W       = 3;
    localparam int CHARS_WORD  = 8;
    localparam int DESC_BITS   = 42;
    localparam int FIFO_DEPTH  = 32;

    ////////////////////////////////////////////////////////////////////////
    // Descriptor field positions within a word
    localparam int UNIT_HI     = 45;
    localparam int UNIT_LO     = 41;
    localparam int WCNT_HI     = 40;
    localparam int WCNT_LO     = 31;
    localparam int INHIBIT_BIT = 30;
    localparam int BINARY_BIT  = 27;
    localparam int DIR_BIT     = 26;
    localparam int WMODE_BIT   = 25;
    localparam int INPUT_BIT   = 24;
    localparam int ERR_HI      = 22;
    localparam int ERR_LO      = 16;
    localparam int ADDR_HI     = 15;
    localparam int ADDR_LO     = 1;

    // Error field bit raised when a binary record ends mid-word
    localparam int PART_ERR    = 0;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [WORD_W-1:0] WORD_RST = 48'h0000_0000_0000;
    localparam logic [POS_W-1:0]  POS_RST  = 3'h0;
    localparam logic [POS_W-1:0]  POS_LAST = 3'h7;

    // Descriptor register: 42 storage bits, no cells for 23, 28, 29
    typedef struct packed {
        logic [4:0]  unit;
        logic [9:0]  wcount;
        logic        inhibit;
        logic        binary;
        logic        backward;
        logic        word_mode;
        logic        input_op;
        logic [6:0]  err;
        logic [14:0] addr;
    } iwb_desc_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DFETCH, ST_DLOAD, ST_RUN_IN, ST_STORE,
        ST_FETCH, ST_UNLOAD, ST_WAIT_END
    } iwb_state_t;

endpackage : iwb_pkg

//--- iwb_fifo.sv
// Character FIFO between the word buffer and the peripheral output.
// Assumes a single clock; both sides use valid/ready handshakes.
`timescale 1ns/1ps
module iwb_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Power-of-two depth lets pointers wrap
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("iwb_fifo: DEPTH must be a power of two >= 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 cnt;
    } iwb_fifo_st_t;

    iwb_fifo_st_t st_q, st_d;
    logic         push;
    logic         pop;

    // Full and empty from the occupancy count
    assign in_ready_out  = (st_q.cnt != (AW+1)'(DEPTH));
    assign out_valid_out = (st_q.cnt != '0);
    assign out_data_out  = st_q.mem[st_q.rd];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // Next state of storage and pointers
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr] = in_data_in;
            st_d.wr           = st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = st_q.rd + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : iwb_fifo

//--- iwb_channel.sv
// Channel control unit datapath: one 48-bit word buffer between core
// memory (whole words) and a peripheral (6-bit characters), steered by a
// 42-bit descriptor register.
// Assumes memory holds req until ack; peripheral inputs are synchronous.
//
// Overview of operation
// - Memory moves whole 48-bit words in parallel
// - Peripheral moves one 6-bit character at a time
// - One word buffer filled or emptied by characters
// - Descriptor goes to word buffer, then descriptor register
// - Descriptor register: 42 bits, no 23, 28, 29
// - Bits 45..41 select the peripheral unit
// - Word count in bits 40..31 ends memory transfer in word or binary mode
// - Bit 30 set: no memory data accesses
// - Bit 27: binary whole words, else alphanumeric partial
// - Bit 26: tape forward when clear, backward set
// - Bit 25 set: word mode, else character mode
// - Bit 24 set: input, clear: output
// - Bits 22..16 collect errors and control flags
// - Bits 15..1 address every memory data access
// - Position counter picks character; 0 is most significant
// - Full input word stored, next word started
`timescale 1ns/1ps
module iwb_channel
    import iwb_pkg::*;
#(
    parameter int FIFO_DEPTH_P = 32
) (
    input  wire logic                    ref_clk_in,
    input  wire logic                    rst_in,
    input  wire logic                    commence_timing_flag_in,
    input  wire logic [14:0]             desc_addr_in,
    output logic                         mem_req_out,
    output logic                         mem_we_out,
    output logic      [14:0]             mem_addr_out,
    output logic      [iwb_pkg::WORD_W-1:0] mem_wdata_out,
    input  wire logic                    mem_ack_in,
    input  wire logic [iwb_pkg::WORD_W-1:0] mem_rdata_in,
    input  wire logic                    char_in_valid_in,
    output logic                         char_in_ready_out,
    input  wire logic [iwb_pkg::CHAR_W-1:0] char_in_data_in,
    output logic                         char_out_valid_out,
    input  wire logic                    char_out_ready_in,
    output logic      [iwb_pkg::CHAR_W-1:0] char_out_data_out,
    input  wire logic                    rec_end_in,
    input  wire logic [6:0]              periph_err_in,
    output logic      [4:0]              unit_sel_out,
    output logic                         tape_backward_out,
    output logic                         input_op_out,
    output logic                         binary_out,
    output logic                         busy_out,
    output logic                         done_out,
    output logic      [iwb_pkg::WORD_W-1:0] result_desc_out
);
    import iwb_pkg::*;

    if (FIFO_DEPTH_P < 2) begin : g_chk
        $error("iwb_channel: FIFO_DEPTH_P must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Character at pos; position 0 is the top one
    function automatic logic [CHAR_W-1:0] get_char(
        input logic [WORD_W-1:0] w,
        input logic [POS_W-1:0]  pos
    );
        logic [WORD_W-1:0] s;
        s = w << (CHAR_W * int'(pos));
        return s[WORD_W-1 -: CHAR_W];
    endfunction : get_char

    // Word with character pos replaced
    function automatic logic [WORD_W-1:0] put_char(
        input logic [WORD_W-1:0] w,
        input logic [POS_W-1:0]  pos,
        input logic [CHAR_W-1:0] c
    );
        logic [WORD_W-1:0] m;
        logic [WORD_W-1:0] v;
        m = {{CHAR_W{1'b1}}, {(WORD_W-CHAR_W){1'b0}}} >> (CHAR_W*int'(pos));
        v = {c, {(WORD_W-CHAR_W){1'b0}}} >> (CHAR_W * int'(pos));
        return (w & ~m) | v;
    endfunction : put_char

    // Descriptor word to register; unused bits dropped
    function automatic iwb_desc_t unpack_desc(input logic [WORD_W-1:0] w);
        iwb_desc_t d;
        d.unit      = w[UNIT_HI:UNIT_LO];
        d.wcount    = w[WCNT_HI:WCNT_LO];
        d.inhibit   = w[INHIBIT_BIT];
        d.binary    = w[BINARY_BIT];
        d.backward  = w[DIR_BIT];
        d.word_mode = w[WMODE_BIT];
        d.input_op  = w[INPUT_BIT];
        d.err       = w[ERR_HI:ERR_LO];
        d.addr      = w[ADDR_HI:ADDR_LO];
        return d;
    endfunction : unpack_desc

    // Register back to descriptor layout; missing cells read zero
    function automatic logic [WORD_W-1:0] pack_desc(input iwb_desc_t d);
        logic [WORD_W-1:0] w;
        w                   = WORD_RST;
        w[UNIT_HI:UNIT_LO]  = d.unit;
        w[WCNT_HI:WCNT_LO]  = d.wcount;
        w[INHIBIT_BIT]      = d.inhibit;
        w[BINARY_BIT]       = d.binary;
        w[DIR_BIT]          = d.backward;
        w[WMODE_BIT]        = d.word_mode;
        w[INPUT_BIT]        = d.input_op;
        w[ERR_HI:ERR_LO]    = d.err;
        w[ADDR_HI:ADDR_LO]  = d.addr;
        return w;
    endfunction : pack_desc

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        iwb_state_t        st;
        logic [WORD_W-1:0] w;
        iwb_desc_t         d;
        logic [POS_W-1:0]  pos;
        logic              fin_pend;
        logic              done;
    } iwb_chan_st_t;

    iwb_chan_st_t       s_q, s_d;
    logic               count_mode;
    logic               fifo_in_valid;
    logic               fifo_in_ready;
    logic               char_take;
    logic [CHAR_W-1:0]  unload_char;

    // Word count governs whole-word transfers
    assign count_mode    = s_q.d.word_mode || s_q.d.binary;
    assign unload_char   = get_char(s_q.w, s_q.pos);
    assign fifo_in_valid = (s_q.st == ST_UNLOAD);
    assign char_in_ready_out = (s_q.st == ST_RUN_IN) ||
                               (s_q.st == ST_WAIT_END);
    assign char_take     = char_in_valid_in && char_in_ready_out;

    // Memory side: one word per handshake, address from descriptor, desc_addr_in for the descriptor fetch
    assign mem_req_out   = (s_q.st == ST_DFETCH) || (s_q.st == ST_STORE) ||
                           (s_q.st == ST_FETCH);
    assign mem_we_out    = (s_q.st == ST_STORE);
    assign mem_addr_out  = (s_q.st == ST_DFETCH) ? desc_addr_in
                                                 : s_q.d.addr;
    assign mem_wdata_out = s_q.w;

    // Descriptor-derived controls, plus busy and done status from the state
    assign unit_sel_out      = s_q.d.unit;
    assign tape_backward_out = s_q.d.backward;
    assign input_op_out      = s_q.d.input_op;
    assign binary_out        = s_q.d.binary;
    assign busy_out          = (s_q.st != ST_IDLE);
    assign done_out          = s_q.done;
    assign result_desc_out   = pack_desc(s_q.d);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        // Errors gather into the descriptor while busy, except during the descriptor fetch
        if (s_q.st != ST_IDLE && s_q.st != ST_DFETCH) begin
            s_d.d.err = s_q.d.err | periph_err_in;
        end
        unique case (s_q.st)
            ST_IDLE: begin
                if (commence_timing_flag_in) begin
                    s_d.st = ST_DFETCH;
                end
            end
            ST_DFETCH: begin
                if (mem_ack_in) begin
                    s_d.w  = mem_rdata_in;
                    s_d.st = ST_DLOAD;
                end
            end
            ST_DLOAD: begin
                s_d.d        = unpack_desc(s_q.w);
                s_d.d.err    = s_d.d.err | periph_err_in;
                s_d.w        = WORD_RST;
                s_d.pos      = POS_RST;
                s_d.fin_pend = 1'b0;
                if (s_q.w[INHIBIT_BIT]) begin
                    s_d.st = ST_WAIT_END;
                end else if ((s_q.w[WMODE_BIT] || s_q.w[BINARY_BIT]) &&
                             s_q.w[WCNT_HI:WCNT_LO] == '0) begin
                    s_d.st   = ST_IDLE;
                    s_d.done = 1'b1;
                end else if (s_q.w[INPUT_BIT]) begin
                    s_d.st = ST_RUN_IN;
                end else begin
                    s_d.st = ST_FETCH;
                end
            end
            ST_RUN_IN: begin
                if (char_take) begin
                    s_d.w = put_char(s_q.w, s_q.pos, char_in_data_in);
                    if (s_q.pos == POS_LAST) begin
                        s_d.st = ST_STORE;
                    end else begin
                        s_d.pos = s_q.pos + 1'b1;
                    end
                end else if (rec_end_in) begin
                    if (s_q.pos == POS_RST) begin
                        s_d.st   = ST_IDLE;
                        s_d.done = 1'b1;
                    end else begin
                        // Partial last word: allowed only for alpha
                        if (s_q.d.binary) begin
                            s_d.d.err[PART_ERR] = 1'b1;
                        end
                        s_d.fin_pend = 1'b1;
                        s_d.st       = ST_STORE;
                    end
                end
            end
            ST_STORE: begin
                if (mem_ack_in) begin
                    s_d.d.addr   = s_q.d.addr + 15'h1;
                    s_d.d.wcount = s_q.d.wcount - 10'h1;
                    s_d.w        = WORD_RST;
                    s_d.pos      = POS_RST;
                    if (s_q.fin_pend ||
                        (count_mode && s_q.d.wcount == 10'h1)) begin
                        s_d.st   = ST_IDLE;
                        s_d.done = 1'b1;
                    end else begin
                        s_d.st = ST_RUN_IN;
                    end
                end
            end
            ST_FETCH: begin
                if (mem_ack_in) begin
                    s_d.w        = mem_rdata_in;
                    s_d.d.addr   = s_q.d.addr + 15'h1;
                    s_d.d.wcount = s_q.d.wcount - 10'h1;
                    s_d.pos      = POS_RST;
                    s_d.st       = ST_UNLOAD;
                end else if (rec_end_in && !count_mode) begin
                    s_d.st   = ST_IDLE;
                    s_d.done = 1'b1;
                end
            end
            ST_UNLOAD: begin
                if (fifo_in_ready) begin
                    if (s_q.pos != POS_LAST) begin
                        s_d.pos = s_q.pos + 1'b1;
                    end else if (count_mode && s_q.d.wcount == '0) begin
                        s_d.st   = ST_IDLE;
                        s_d.done = 1'b1;
                    end else begin
                        s_d.st = ST_FETCH;
                    end
                end else if (rec_end_in && !count_mode) begin
                    s_d.st   = ST_IDLE;
                    s_d.done = 1'b1;
                end
            end
            ST_WAIT_END: begin
                // No memory traffic; input characters dropped
                if (rec_end_in && !char_take) begin
                    s_d.st   = ST_IDLE;
                    s_d.done = 1'b1;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '{st: ST_IDLE, w: WORD_RST, d: '0, pos: POS_RST,
                     fin_pend: 1'b0, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output characters toward the peripheral
    iwb_fifo #(
        .WIDTH (CHAR_W),
        .DEPTH (FIFO_DEPTH_P)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (fifo_in_valid),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (unload_char),
        .out_valid_out (char_out_valid_out),
        .out_ready_in  (char_out_ready_in),
        .out_data_out  (char_out_data_out)
    );

endmodule : iwb_channel

//--- iwb_monitor.sv
// Checker bound onto the channel's ports.
// Assumes ref_clk_in and async high rst_in.
`timescale 1ns/1ps
module iwb_monitor
    import iwb_pkg::*;
(
    input wire logic                       ref_clk_in,
    input wire logic                       rst_in,
    input wire logic                       commence_timing_flag_in,
    input wire logic [14:0]                desc_addr_in,
    input wire logic                       mem_req_out,
    input wire logic                       mem_we_out,
    input wire logic [14:0]                mem_addr_out,
    input wire logic [iwb_pkg::WORD_W-1:0] mem_wdata_out,
    input wire logic                       mem_ack_in,
    input wire logic                       char_in_ready_out,
    input wire logic                       char_out_valid_out,
    input wire logic                       char_out_ready_in,
    input wire logic [iwb_pkg::CHAR_W-1:0] char_out_data_out,
    input wire logic [4:0]                 unit_sel_out,
    input wire logic                       tape_backward_out,
    input wire logic                       input_op_out,
    input wire logic                       binary_out,
    input wire logic                       busy_out,
    input wire logic                       done_out,
    input wire logic [iwb_pkg::WORD_W-1:0] result_desc_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////////
    // Memory side
    req_stand_a: assert property (mem_req_out && !mem_ack_in |=>
        mem_req_out && $stable(mem_we_out) && $stable(mem_addr_out))
        else $error("request changed");
    wdata_stand_a: assert property (mem_req_out && mem_we_out &&
        !mem_ack_in |=> $stable(mem_wdata_out))
        else $error("store word changed");
    start_fetch_a: assert property (!busy_out && commence_timing_flag_in
        |=> mem_req_out && !mem_we_out && mem_addr_out == desc_addr_in)
        else $error("no descriptor fetch");
    store_addr_a: assert property (mem_req_out && mem_we_out |->
        mem_addr_out == result_desc_out[ADDR_HI:ADDR_LO])
        else $error("bad store address");
    store_step_a: assert property (mem_req_out && mem_we_out &&
        mem_ack_in |=> result_desc_out[ADDR_HI:ADDR_LO] ==
        $past(mem_addr_out) + 15'h1 && result_desc_out[WCNT_HI:WCNT_LO]
        == $past(result_desc_out[WCNT_HI:WCNT_LO]) - 10'h1)
        else $error("no step after store");
    store_block_a: assert property (mem_req_out && mem_we_out |->
        !char_in_ready_out)
        else $error("ready during store");

    ////////////////////////////////////////////////////////////////////////
    // Control outputs
    idle_quiet_a: assert property (!busy_out |->
        !mem_req_out && !char_in_ready_out)
        else $error("activity while idle");
    done_pulse_a: assert property (done_out |-> !busy_out ##1 !done_out)
        else $error("bad done pulse");
    rsv_zero_a: assert property (result_desc_out[47:46] == 2'h0 &&
        result_desc_out[29:28] == 2'h0 && !result_desc_out[23] &&
        !result_desc_out[0])
        else $error("missing cell nonzero");
    field_out_a: assert property (
        unit_sel_out == result_desc_out[UNIT_HI:UNIT_LO] &&
        tape_backward_out == result_desc_out[DIR_BIT] &&
        input_op_out == result_desc_out[INPUT_BIT] &&
        binary_out == result_desc_out[BINARY_BIT])
        else $error("field output mismatch");
    char_hold_a: assert property (char_out_valid_out &&
        !char_out_ready_in |=> char_out_valid_out &&
        $stable(char_out_data_out))
        else $error("stalled char lost");

    // Main scenarios reached
    cover property (mem_req_out && mem_we_out && mem_ack_in);
    cover property (done_out && input_op_out);
    cover property (char_out_valid_out && !char_out_ready_in);
endmodule : iwb_monitor

//--- iwb_mem_model.sv
// Core memory partner: whole-word reads and writes after a random wait.
// Assumes req stands until its one-cycle ack.
`timescale 1ns/1ps
module iwb_mem_model
    import iwb_pkg::*;
(
    input  wire logic                       ref_clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       req_in,
    input  wire logic                       we_in,
    input  wire logic [14:0]                addr_in,
    input  wire logic [iwb_pkg::WORD_W-1:0] wdata_in,
    output logic                            ack_out,
    output logic      [iwb_pkg::WORD_W-1:0] rdata_out
);
    logic [WORD_W-1:0] mem [int];
    int                wr_count = 0;
    int                wait_q;

    // Ack after 0 to 2 waits; rdata toggles when stale
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_out   <= 1'b0;
            rdata_out <= 48'h5555_5555_5555;
            wait_q = 0;
        end else if (ack_out || !req_in || wait_q > 0) begin
            ack_out   <= 1'b0;
            rdata_out <= ~rdata_out;
            if (req_in && !ack_out && wait_q > 0) wait_q--;
        end else begin
            ack_out <= 1'b1;
            wait_q = $urandom % 3;
            if (we_in) begin
                mem[int'(addr_in)] = wdata_in;
                wr_count++;
            end else begin
                rdata_out <= mem[int'(addr_in)];
            end
        end
    end
endmodule : iwb_mem_model

//--- iwb_tb.sv
// Bench: input, output, partial, inhibited and empty runs
// against a queue model. Assumes iwb_pkg and the design.
`timescale 1ns/1ps
module testbench;
    import iwb_pkg::*;
    localparam logic [14:0] DA  = 15'h0100;
    localparam logic [47:0] RSV = 48'hc000_3080_0001;
    logic              ref_clk_in, rst_in, commence_timing_flag_in;
    logic [14:0]       desc_addr_in, mem_addr_out;
    logic              mem_req_out, mem_we_out, mem_ack_in;
    logic [WORD_W-1:0] mem_wdata_out, mem_rdata_in, result_desc_out;
    logic              char_in_valid_in, char_in_ready_out, rec_end_in;
    logic [CHAR_W-1:0] char_in_data_in, char_out_data_out;
    logic              char_out_valid_out, char_out_ready_in;
    logic [6:0]        periph_err_in;
    logic [4:0]        unit_sel_out;
    logic              tape_backward_out, input_op_out, binary_out;
    logic              busy_out, done_out;
    int                fail_count, cmp_count, done_cnt;

    iwb_channel #(.FIFO_DEPTH_P(4)) dut (.ref_clk_in, .rst_in,
        .commence_timing_flag_in, .desc_addr_in, .mem_req_out, .mem_we_out,
        .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_rdata_in,
        .char_in_valid_in, .char_in_ready_out, .char_in_data_in,
        .char_out_valid_out, .char_out_ready_in, .char_out_data_out,
        .rec_end_in, .periph_err_in, .unit_sel_out, .tape_backward_out,
        .input_op_out, .binary_out, .busy_out, .done_out, .result_desc_out);
    iwb_mem_model mem_i (.ref_clk_in, .rst_in, .req_in(mem_req_out),
        .we_in(mem_we_out), .addr_in(mem_addr_out),
        .wdata_in(mem_wdata_out), .ack_out(mem_ack_in),
        .rdata_out(mem_rdata_in));

    ////////////////////////////////////////////////////////////////////////
    // Clock, done counter and watchdog
    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) if (done_out === 1'b1) done_cnt++;
    initial begin
        #300000;
        fail_count++;
        $display("Error %0t: watchdog expired", $time);
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [47:0] mk(input logic [4:0] u,
        input logic [9:0] c, input logic [4:0] fl, input logic [6:0] e,
        input logic [14:0] a);
        mk = '0;
        mk[UNIT_HI:UNIT_LO] = u;
        mk[WCNT_HI:WCNT_LO] = c;
        mk[INHIBIT_BIT] = fl[4];
        mk[BINARY_BIT:INPUT_BIT] = fl[3:0];
        mk[ERR_HI:ERR_LO] = e;
        mk[ADDR_HI:ADDR_LO] = a;
    endfunction : mk
    task automatic tick;
        @(posedge ref_clk_in);
        #1;
    endtask : tick
    // One operation; fl = {inhibit, binary, backward, word mode, input}
    task automatic run(input logic [4:0] u, input logic [9:0] c,
        input logic [4:0] fl, input int nch, input bit rend, input int nw,
        input logic [6:0] xe);
        logic [14:0] a;
        logic [47:0] w;
        logic [47:0] q[$];
        int wc, g, k, d0;
        a  = 15'h2000 | 15'($urandom % 4096);
        wc = mem_i.wr_count;
        d0 = done_cnt;
        w  = '0;
        mem_i.mem[int'(DA)] = mk(u, c, fl, 7'h00, a) | RSV;
        for (k = 0; k < c && !fl[0]; k++) begin
            w = 48'({$urandom, $urandom});
            mem_i.mem[int'(a) + k] = w;
            q.push_back(w);
        end
        commence_timing_flag_in = 1'b1;
        tick();
        commence_timing_flag_in = 1'b0;
        if (fl[0]) begin
            w = '0;
            for (k = 0; k < nch; k++) begin
                char_in_valid_in = 1'b1;
                char_in_data_in  = 6'($urandom);
                w[47 - 6 * (k % 8) -: 6] = char_in_data_in;
                g = 0;
                do begin
                    @(posedge ref_clk_in);
                    g++;
                end while (char_in_ready_out !== 1'b1 && g < 200);
                #1;
                periph_err_in = (k == 0) ? (xe & 7'h7e) : 7'h00;
                if (k % 8 == 7 || (rend && k == nch - 1)) begin
                    q.push_back(w);
                    w = '0;
                end
            end
            char_in_valid_in = 1'b0;
            rec_end_in = rend;
            tick();
            rec_end_in = 1'b0;
        end else begin
            g = 0;
            k = 0;
            while (k < 8 * c && g < 3000) begin
                @(posedge ref_clk_in);
                g++;
                if (char_out_valid_out === 1'b1 && char_out_ready_in) begin
                    chk(char_out_data_out, q[k / 8][47 - 6 * (k % 8) -: 6]);
                    k++;
                end
                #1;
                char_out_ready_in = ($urandom % 3) != 0;
            end
        end
        g = 0;
        while (done_cnt == d0 && g < 3000) begin
            @(posedge ref_clk_in);
            g++;
        end
        #1;
        chk(48'(done_cnt - d0), 48'h1);
        for (k = 0; k < nw && fl[0]; k++)
            chk(mem_i.mem[int'(a) + k], q[k]);
        chk(48'(mem_i.wr_count - wc), 48'(fl[0] ? nw : 0));
        chk(result_desc_out, mk(u, c - 10'(nw), fl, xe, a + 15'(nw)));
        chk({unit_sel_out, tape_backward_out, input_op_out, binary_out},
            {u, fl[2], fl[0], fl[3]});
    endtask : run
    task automatic conclude;
        $display("Mismatches %0d of %0d comparisons", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {commence_timing_flag_in, char_in_valid_in, rec_end_in} = 3'h0;
        desc_addr_in      = DA;
        char_in_data_in   = 6'h00;
        periph_err_in     = 7'h00;
        char_out_ready_in = 1'b1;
        rst_in            = 1'b1;
        {fail_count, cmp_count, done_cnt} = '0;
        void'($urandom(37));
        repeat (2) @(posedge ref_clk_in);
        #1;
        rst_in = 1'b0;
        run(5'h13, 10'h002, 5'b00111, 16, 0, 2, 7'h24);
        run(5'h05, 10'h003, 5'b01011, 11, 1, 2, 7'h01);
        run(5'h1f, 10'h3ff, 5'b00001, 5, 1, 1, 7'h00);
        run(5'h0a, 10'h004, 5'b10001, 5, 1, 0, 7'h00);
        run(5'h11, 10'h000, 5'b00011, 0, 0, 0, 7'h00);
        run(5'h06, 10'h003, 5'b01110, 0, 0, 3, 7'h00);
        for (int i = 0; i < 6; i++) begin
            int n;
            n = 1 + $urandom % 3;
            run(5'($urandom), 10'(n), (i % 2) ? 5'b00011 : 5'b01010,
                8 * n, 0, n, 7'h00);
        end
        conclude();
    end
endmodule : testbench

bind iwb_channel iwb_monitor mon (.ref_clk_in, .rst_in,
    .commence_timing_flag_in, .desc_addr_in, .mem_req_out, .mem_we_out,
    .mem_addr_out, .mem_wdata_out, .mem_ack_in, .char_in_ready_out,
    .char_out_valid_out, .char_out_ready_in, .char_out_data_out,
    .unit_sel_out, .tape_backward_out, .input_op_out, .binary_out,
    .busy_out, .done_out, .result_desc_out);
